// file: csr_bus_partner.sv
// Model of the memories on the local bus: select pull-ups, strap and ready
`timescale 1ns/1ps
module csr_bus_partner (
  input wire logic       clk,
  input wire logic       strap_low,
  input wire logic [3:0] stall,
  input wire logic       up_o,
  input wire logic       up_oe_n,
  input wire logic       lo_o,
  input wire logic       lo_oe_n,
  input wire logic [1:0] mid_o,
  input wire logic [1:0] mid_oe_n,
  output logic           ext_ready,
  output logic           up_i,
  output logic           lo_i,
  output logic [1:0]     mid_i
);
  logic [3:0] busy_cnt;
  // Pull-ups win on a released pin unless the strap pulls it low
  assign up_i      = up_oe_n ? !strap_low : up_o;
  assign lo_i      = lo_oe_n ? !strap_low : lo_o;
  assign mid_i     = mid_o | mid_oe_n;
  // A slow device holds ready low for stall cycles after its upper or lower select goes low
  assign ext_ready = busy_cnt >= stall;
  initial busy_cnt = 4'h0;
  always @(posedge clk) begin
    if (up_o && lo_o) begin
      busy_cnt <= 4'h0;
    end else if (busy_cnt != 4'hF) begin
      busy_cnt <= busy_cnt + 4'h1;
    end
  end
endmodule

// file: csr_chip_select.sv
// Chip-select and ready generation logic with its control registers
`timescale 1ns/1ps
module csr_chip_select #(
  parameter int NUM_PER = 7
) (
  input  wire logic        clk,
  input  wire logic        srst,
  // Control register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_offset,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  // Bus cycle from the bus interface unit
  input  wire logic        cyc_start,
  input  wire logic        cyc_active,
  input  wire logic [19:0] cyc_addr,
  input  wire logic        cyc_io,
  input  wire logic [1:0]  cyc_src,
  output logic             ctl_block_claim,
  output logic             ready_out,
  input  wire logic        ext_ready_pin,
  input  wire logic        enhanced_mode,
  // Select pins
  output logic             upper_mem_select_n_o,
  output logic             upper_mem_select_n_oe_n,
  input  wire logic        upper_mem_select_n_i,
  output logic             lower_mem_select_n_o,
  output logic             lower_mem_select_n_oe_n,
  input  wire logic        lower_mem_select_n_i,
  output logic [3:0]       mid_mem_select_n_o,
  output logic [3:0]       mid_mem_select_n_oe_n,
  input  wire logic [1:0]  mid_mem_select_n_i,
  output logic [NUM_PER-1:0] periph_select_n_o,
  output logic             periph_select_n_oe_n,
  output logic [1:0]       latched_addr_o,
  output logic             coproc_ext_request,
  output logic             coproc_error,
  output logic             pin_float_test_mode,
  output logic             pullup_en
);
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] upper_region_select_control_reg;
  logic [15:0] upper_region_select_control_next;
  logic [15:0] lower_ctl_reg;
  logic [15:0] lower_ctl_next;
  logic [15:0] periph_ctl_reg;
  logic [15:0] periph_ctl_next;
  logic [15:0] mid_base_reg;
  logic [15:0] mid_base_next;
  logic [15:0] mid_ctl_reg;
  logic [15:0] mid_ctl_next;
  logic [15:0] coproc_ctl_reg;
  logic [15:0] coproc_ctl_next;
  logic [15:0] reloc_reg;
  logic [15:0] reloc_next;
  logic [2:0]  prog_reg;
  logic [2:0]  prog_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    upper_region_select_control_next = upper_region_select_control_reg;
    lower_ctl_next  = lower_ctl_reg;
    periph_ctl_next = periph_ctl_reg;
    mid_base_next   = mid_base_reg;
    mid_ctl_next    = mid_ctl_reg;
    coproc_ctl_next = coproc_ctl_reg;
    reloc_next      = reloc_reg;
    prog_next       = prog_reg;
    rdata_next      = rdata_reg;
    if (reg_wr) begin
      case (reg_offset)
        csr_pkg::CSR_OFF_UPPER:  upper_region_select_control_next = reg_wdata;
        csr_pkg::CSR_OFF_LOWER: begin
          lower_ctl_next = reg_wdata;
          prog_next[0]   = 1'b1;
        end
        csr_pkg::CSR_OFF_PERIPH: begin
          periph_ctl_next = reg_wdata;
          prog_next[1]    = 1'b1;
        end
        csr_pkg::CSR_OFF_MIDBAS: mid_base_next = reg_wdata;
        csr_pkg::CSR_OFF_MIDCTL: begin
          mid_ctl_next = reg_wdata;
          prog_next[2] = 1'b1;
        end
        csr_pkg::CSR_OFF_COPROC: begin
          if (enhanced_mode) begin
            coproc_ctl_next = reg_wdata;
          end
        end
        csr_pkg::CSR_OFF_RELOC:  reloc_next = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_offset)
        csr_pkg::CSR_OFF_UPPER:  rdata_next = upper_region_select_control_reg;
        csr_pkg::CSR_OFF_LOWER:  rdata_next = lower_ctl_reg;
        csr_pkg::CSR_OFF_PERIPH: rdata_next = periph_ctl_reg;
        csr_pkg::CSR_OFF_MIDBAS: rdata_next = mid_base_reg;
        csr_pkg::CSR_OFF_MIDCTL: rdata_next = mid_ctl_reg;
        csr_pkg::CSR_OFF_COPROC: rdata_next = enhanced_mode ? coproc_ctl_reg
                                                         : csr_pkg::CSR_ZERO16;
        csr_pkg::CSR_OFF_RELOC:  rdata_next = reloc_reg;
        default:                 rdata_next = csr_pkg::CSR_ZERO16;
      endcase
    end
    if (srst) begin
      upper_region_select_control_next = csr_pkg::CSR_UPPER_RST;
      lower_ctl_next  = csr_pkg::CSR_ZERO16;
      periph_ctl_next = csr_pkg::CSR_ZERO16;
      mid_base_next   = csr_pkg::CSR_ZERO16;
      mid_ctl_next    = csr_pkg::CSR_ZERO16;
      coproc_ctl_next = csr_pkg::CSR_ZERO16;
      reloc_next      = csr_pkg::CSR_RELOC_RST;
      prog_next       = 3'h0;
      rdata_next      = csr_pkg::CSR_ZERO16;
    end
  end

  always_ff @(posedge clk) begin
    upper_region_select_control_reg <= upper_region_select_control_next;
    lower_ctl_reg  <= lower_ctl_next;
    periph_ctl_reg <= periph_ctl_next;
    mid_base_reg   <= mid_base_next;
    mid_ctl_reg    <= mid_ctl_next;
    coproc_ctl_reg <= coproc_ctl_next;
    reloc_reg      <= reloc_next;
    prog_reg       <= prog_next;
    rdata_reg      <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Mask keeping address bits at or above the mid block size
  function automatic logic [19:0] mid_mask(input logic [2:0] size_code);
    logic [19:0] m;
    m = 20'hFFFFF;
    for (int k = 0; k < 7; k++) begin
      if (3'(k) < size_code) begin
        m[csr_pkg::CSR_MID_BLK_SH + k] = 1'b0;
      end
    end
    m[csr_pkg::CSR_MID_BLK_SH-1:0] = '0;
    return m;
  endfunction

  logic [19:0] mid_base_addr;
  logic [19:0] mid_msk;
  logic [2:0]  mid_code;
  logic [1:0]  mid_quarter;
  logic        mem_cyc;
  logic        hit_upper;
  logic        hit_lower;
  logic        hit_mid;
  logic        hit_per;
  logic [2:0]  per_index;
  logic        hit_any;
  logic [1:0]  wait_sel;
  logic        ign_sel;

  assign mem_cyc   = !cyc_io;
  // Refresh, DMA and CPU cycles decode alike
  assign hit_upper = mem_cyc && (cyc_addr[19:10] >=
    upper_region_select_control_reg[15:csr_pkg::CSR_ADDR_LSB]);
  assign hit_lower = mem_cyc && prog_reg[0] && (cyc_addr[19:10] <=
    lower_ctl_reg[15:csr_pkg::CSR_ADDR_LSB]);
  assign mid_code  = mid_ctl_reg[csr_pkg::CSR_MID_SIZE_LSB +: 3];
  assign mid_msk   = mid_mask(mid_code);
  assign mid_base_addr = {mid_base_reg[15:csr_pkg::CSR_MID_BASE_LSB],
                          13'h0000};
  assign hit_mid   = mem_cyc && prog_reg[2] && !hit_upper && !hit_lower &&
    ((cyc_addr & mid_msk) == (mid_base_addr & mid_msk));
  // Quarter of the block picks one of four lines
  assign mid_quarter = 2'((cyc_addr & ~mid_msk) >>
                       (csr_pkg::CSR_MID_BLK_SH - 2 + int'(mid_code)));
  assign per_index = cyc_addr[9:7];
  assign hit_per   = prog_reg[1] &&
    (cyc_io == periph_ctl_reg[csr_pkg::CSR_PER_IO_BIT]) &&
    (cyc_addr[19:10] == periph_ctl_reg[15:csr_pkg::CSR_ADDR_LSB]) &&
    (per_index != csr_pkg::CSR_PER_LAST);
  assign hit_any   = hit_upper || hit_lower || hit_mid || hit_per;

  // Control block claim in its chosen space
  assign ctl_block_claim = cyc_active && (cyc_src != 2'(csr_pkg::CSR_SRC_REFRESH))
    && (cyc_io == reloc_reg[csr_pkg::CSR_RELOC_IO_BIT])
    && (cyc_addr[19:8] == {reloc_reg[11:0]});

  always_comb begin
    wait_sel = 2'h0;
    ign_sel  = 1'b0;
    if (hit_upper) begin
      wait_sel = upper_region_select_control_reg[1:0];
      ign_sel  = upper_region_select_control_reg[csr_pkg::CSR_RDY_IGN_BIT];
    end else if (hit_lower) begin
      wait_sel = lower_ctl_reg[1:0];
      ign_sel  = lower_ctl_reg[csr_pkg::CSR_RDY_IGN_BIT];
    end else if (hit_mid) begin
      wait_sel = mid_ctl_reg[1:0];
      ign_sel  = mid_ctl_reg[csr_pkg::CSR_RDY_IGN_BIT];
    end else if (hit_per) begin
      wait_sel = periph_ctl_reg[1:0];
      ign_sel  = periph_ctl_reg[csr_pkg::CSR_RDY_IGN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic ext_ready_s;
  logic upper_pin_s;
  logic lower_pin_s;
  logic mid0_pin_s;
  logic mid1_pin_s;

  csr_pin_sync #(.RST_VAL(1'b1)) u_sync_rdy (
    .clk(clk), .srst(1'b0), .pin_in(ext_ready_pin), .level_out(ext_ready_s));
  csr_pin_sync #(.RST_VAL(1'b1)) u_sync_up (
    .clk(clk), .srst(1'b0), .pin_in(upper_mem_select_n_i),
    .level_out(upper_pin_s));
  csr_pin_sync #(.RST_VAL(1'b1)) u_sync_lo (
    .clk(clk), .srst(1'b0), .pin_in(lower_mem_select_n_i),
    .level_out(lower_pin_s));
  csr_pin_sync #(.RST_VAL(1'b0)) u_sync_m0 (
    .clk(clk), .srst(srst), .pin_in(mid_mem_select_n_i[0]),
    .level_out(mid0_pin_s));
  csr_pin_sync #(.RST_VAL(1'b0)) u_sync_m1 (
    .clk(clk), .srst(srst), .pin_in(mid_mem_select_n_i[1]),
    .level_out(mid1_pin_s));

  csr_wait_gen u_wait (
    .clk(clk), .srst(srst), .cyc_start(cyc_start), .cyc_active(cyc_active),
    .hit(hit_any), .wait_count(wait_sel), .ignore_ext(ign_sel),
    .ext_ready(ext_ready_s), .ready_out(ready_out));

  // ---------------------------------------------------------------
  // Select outputs, latched address, float strap
  // ---------------------------------------------------------------
  logic                 up_reg;
  logic                 up_next;
  logic                 lo_reg;
  logic                 lo_next;
  logic [3:0]           mid_reg;
  logic [3:0]           mid_next;
  logic [NUM_PER-1:0]   per_reg;
  logic [NUM_PER-1:0]   per_next;
  logic [1:0]           la_reg;
  logic [1:0]           la_next;
  logic                 rst_d_reg;
  logic                 float_reg;
  logic                 float_next;
  logic [1:0]           cop_reg;
  logic [1:0]           cop_next;

  always_comb begin
    up_next    = 1'b1;
    lo_next    = 1'b1;
    mid_next   = 4'hF;
    per_next   = '1;
    la_next    = la_reg;
    float_next = float_reg;
    cop_next   = {mid1_pin_s, mid0_pin_s};
    if (cyc_start) begin
      la_next = cyc_addr[2:1];
    end
    if (cyc_active) begin
      up_next = !hit_upper;
      lo_next = !hit_lower;
      if (hit_mid) begin
        mid_next[mid_quarter] = 1'b0;
      end
      if (hit_per) begin
        per_next[per_index] = 1'b0;
      end
    end
    // Numeric unit select: enhanced I/O cycles to the coprocessor window
    if (enhanced_mode) begin
      mid_next[3] = !(cyc_active && cyc_io && coproc_ctl_reg[0] &&
                      (cyc_addr[15:8] == coproc_ctl_reg[15:8]));
    end
    // Strap sampled on the first edge after reset release
    if (rst_d_reg && !srst) begin
      float_next = !upper_pin_s && !lower_pin_s;
    end
    if (srst) begin
      up_next  = 1'b1;
      lo_next  = 1'b1;
      mid_next = 4'hF;
      per_next = '1;
      la_next  = 2'h0;
      cop_next = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    up_reg    <= up_next;
    lo_reg    <= lo_next;
    mid_reg   <= mid_next;
    per_reg   <= per_next;
    la_reg    <= la_next;
    rst_d_reg <= srst;
    float_reg <= float_next;
    cop_reg   <= cop_next;
  end

  assign upper_mem_select_n_o    = up_reg;
  assign lower_mem_select_n_o    = lo_reg;
  assign mid_mem_select_n_o      = mid_reg;
  assign periph_select_n_o       = per_reg;
  assign latched_addr_o          = la_reg;
  assign coproc_ext_request      = cop_reg[0];
  assign coproc_error            = cop_reg[1];
  assign pin_float_test_mode     = float_reg;
  // Strap pins rest on their pull-ups in reset so the strap can be seen
  assign pullup_en               = srst;
  assign upper_mem_select_n_oe_n = float_reg || srst;
  assign lower_mem_select_n_oe_n = float_reg || srst;
  assign periph_select_n_oe_n    = float_reg;
  // In enhanced mode lines 0 and 1 become inputs
  assign mid_mem_select_n_oe_n   = {float_reg, float_reg,
                                    float_reg || enhanced_mode,
                                    float_reg || enhanced_mode};
endmodule

// file: csr_chip_select_properties.sv
// Port checker for the chip-select and ready generator
`timescale 1ns/1ps
module csr_chip_select_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_offset,
  input wire logic [15:0] reg_wdata,
  input wire logic        cyc_start,
  input wire logic        cyc_active,
  input wire logic [19:0] cyc_addr,
  input wire logic        cyc_io,
  input wire logic [1:0]  cyc_src,
  input wire logic        ctl_block_claim,
  input wire logic        ready_out,
  input wire logic        ext_ready_pin,
  input wire logic        upper_mem_select_n_o,
  input wire logic        upper_mem_select_n_oe_n,
  input wire logic        lower_mem_select_n_o,
  input wire logic        lower_mem_select_n_oe_n,
  input wire logic [1:0]  latched_addr_o,
  input wire logic        pin_float_test_mode,
  input wire logic        pullup_en
);
  logic [15:0] up_reg, up_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic        uc_reg, uc_next, lw_reg, lw_next, uhit;
  // Mirror of the upper control and of the bus cycle in flight
  always_comb begin
    uhit     = !cyc_io && cyc_addr[19:10] >= up_reg[15:6];
    up_next  = up_reg;
    if (reg_wr && reg_offset == csr_pkg::CSR_OFF_UPPER) begin
      up_next = reg_wdata;
    end
    lw_next  = lw_reg || (reg_wr && reg_offset == csr_pkg::CSR_OFF_LOWER);
    cnt_next = cyc_start ? 8'h01 : (cyc_active ? cnt_reg + 8'h01 : 8'h00);
    uc_next  = cyc_active && (cyc_start ? uhit : uc_reg);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      {up_reg, cnt_reg, uc_reg, lw_reg} <= {csr_pkg::CSR_UPPER_RST, 10'h000};
    end else begin
      {up_reg, cnt_reg, uc_reg, lw_reg} <= {up_next, cnt_next, uc_next, lw_next};
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst; disable iff (1'b0)
    srst |=> upper_mem_select_n_o && lower_mem_select_n_o; endproperty
  a_rst: assert property (p_rst)
    else $error("select low after a reset edge");
  property p_pull; disable iff (1'b0) pullup_en == srst && (!srst ||
    (upper_mem_select_n_oe_n && lower_mem_select_n_oe_n)); endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up window differs from reset");
  property p_float; pin_float_test_mode |->
    upper_mem_select_n_oe_n && lower_mem_select_n_oe_n; endproperty
  a_float: assert property (p_float)
    else $error("pin driven in float mode");
  property p_updec; !pin_float_test_mode |->
    upper_mem_select_n_o == !$past(cyc_active && uhit); endproperty
  a_updec: assert property (p_updec)
    else $error("upper select does not follow decode");
  property p_lowidle; !lw_reg |-> lower_mem_select_n_o; endproperty
  a_lowidle: assert property (p_lowidle)
    else $error("lower select active before programming");
  property p_upmin; uc_reg && ready_out |->
    cnt_reg > {6'h00, up_reg[1:0]}; endproperty
  a_upmin: assert property (p_upmin)
    else $error("ready before the wait states ran out");
  property p_upign; uc_reg && up_reg[2] && cyc_active &&
    cnt_reg == {6'h00, up_reg[1:0]} + 8'h01 |-> ready_out; endproperty
  a_upign: assert property (p_upign)
    else $error("ready late with external ready ignored");
  property p_extgate; (!ext_ready_pin) [*6] ##0
    (uc_reg && !up_reg[2]) |-> !ready_out; endproperty
  a_extgate: assert property (p_extgate)
    else $error("ready while external ready held low");
  property p_la; $past(cyc_start && cyc_active) |->
    latched_addr_o == $past(cyc_addr[2:1]); endproperty
  a_la: assert property (p_la)
    else $error("latched address bits wrong");
  property p_claim; ctl_block_claim |->
    cyc_active && cyc_src != csr_pkg::CSR_SRC_REFRESH; endproperty
  a_claim: assert property (p_claim)
    else $error("control block claimed outside a cycle");
endmodule

bind csr_chip_select csr_chip_select_props u_props (
  .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_offset(reg_offset),
  .reg_wdata(reg_wdata), .cyc_start(cyc_start), .cyc_active(cyc_active),
  .cyc_addr(cyc_addr), .cyc_io(cyc_io), .cyc_src(cyc_src),
  .ctl_block_claim(ctl_block_claim), .ready_out(ready_out),
  .ext_ready_pin(ext_ready_pin), .upper_mem_select_n_o(upper_mem_select_n_o),
  .upper_mem_select_n_oe_n(upper_mem_select_n_oe_n),
  .lower_mem_select_n_o(lower_mem_select_n_o),
  .lower_mem_select_n_oe_n(lower_mem_select_n_oe_n),
  .latched_addr_o(latched_addr_o),
  .pin_float_test_mode(pin_float_test_mode), .pullup_en(pullup_en)
);

// file: csr_chip_select_tb_top.sv
// Self-checking bench for the chip-select and ready generator
`timescale 1ns/1ps
module csr_chip_select_tb_top;
  logic        clk, srst, reg_wr, reg_rd, cyc_start, cyc_active, cyc_io;
  logic [7:0]  reg_offset;
  logic [15:0] reg_wdata, reg_rdata;
  logic [19:0] cyc_addr, sel;
  logic [1:0]  cyc_src, la, mid_i;
  logic        claim, ready, ext_rdy, enh, up_o, up_oe, up_i, per_oe;
  logic        lo_o, lo_oe, lo_i, cpr, cpe, flt, pu, strap;
  logic [3:0]  mid_o, mid_oe, stall;
  logic [6:0]  per_o;
  int          n_fail, checks, n;

  csr_chip_select #(.NUM_PER(7)) DUT (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cyc_start(cyc_start), .cyc_active(cyc_active), .cyc_addr(cyc_addr),
    .cyc_io(cyc_io), .cyc_src(cyc_src), .ctl_block_claim(claim),
    .ready_out(ready), .ext_ready_pin(ext_rdy), .enhanced_mode(enh),
    .upper_mem_select_n_o(up_o), .upper_mem_select_n_oe_n(up_oe),
    .upper_mem_select_n_i(up_i), .lower_mem_select_n_o(lo_o),
    .lower_mem_select_n_oe_n(lo_oe), .lower_mem_select_n_i(lo_i),
    .mid_mem_select_n_o(mid_o), .mid_mem_select_n_oe_n(mid_oe),
    .mid_mem_select_n_i(mid_i), .periph_select_n_o(per_o),
    .periph_select_n_oe_n(per_oe), .latched_addr_o(la),
    .coproc_ext_request(cpr), .coproc_error(cpe),
    .pin_float_test_mode(flt), .pullup_en(pu)
  );
  csr_bus_partner u_far (
    .clk(clk), .strap_low(strap), .stall(stall), .up_o(up_o),
    .up_oe_n(up_oe), .lo_o(lo_o), .lo_oe_n(lo_oe), .mid_o(mid_o[1:0]),
    .mid_oe_n(mid_oe[1:0]), .ext_ready(ext_rdy), .up_i(up_i),
    .lo_i(lo_i), .mid_i(mid_i)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    {reg_wr, reg_offset, reg_wdata} = {1'b1, off, d};
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] off, input logic [15:0] exp);
    {reg_rd, reg_offset} = {1'b1, off};
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(20'(reg_rdata), 20'(exp));
    @(posedge clk);
    #1;
  endtask
  // Runs one bus cycle; n counts cycles to ready, sel holds the selects
  task automatic cyc(input logic [19:0] a, input logic io,
                     input logic [1:0] s);
    {cyc_start, cyc_active, cyc_addr, cyc_io, cyc_src} = {2'b11, a, io, s};
    n = 1;
    @(posedge clk);
    #1 cyc_start = 1'b0;
    sel = {4'h0, mid_o, claim, per_o, la, up_o, lo_o};
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 cyc_active = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rst(input logic s);
    {srst, strap} = {1'b1, s};
    repeat (6) @(posedge clk);
    #1 chk(20'({up_o, lo_o, per_o}), 20'h1FF);
    srst = 1'b0;
    repeat (2) @(posedge clk);
    #1 strap = 1'b0;
    chk(20'({flt, up_oe}), s ? 20'h3 : 20'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {srst, reg_wr, reg_rd, reg_offset, reg_wdata} = '0;
    {cyc_start, cyc_active, cyc_addr, cyc_io, cyc_src} = '0;
    {enh, strap, stall, n_fail, checks, n} = '0;
    #1;
    rst(1'b1);
    rst(1'b0);
    $display("test reset and float done");
    rd(csr_pkg::CSR_OFF_UPPER, csr_pkg::CSR_UPPER_RST);
    rd(8'h10, 16'h0000);
    cyc(20'hFFFF0, 1'b0, 2'h0);
    chk(sel, 20'hF7F1);
    chk(20'(n), 20'h4);
    stall = 4'hA;
    cyc(20'hFFFF0, 1'b0, 2'h0);
    chk(20'(n > 4), 20'h1);
    stall = 4'hF;
    for (int w = 0; w < 4; w++) begin
      wr(csr_pkg::CSR_OFF_UPPER, 16'hFFC4 | 16'(w));
      cyc(20'hFFFF0, 1'b0, 2'(w & 1));
      chk(20'(n), 20'(w + 1));
    end
    stall = 4'h0;
    rd(csr_pkg::CSR_OFF_UPPER, 16'hFFC7);
    $display("test upper waits done");
    cyc(20'h00006, 1'b0, 2'h0);
    chk(sel, 20'hF7FF);
    wr(csr_pkg::CSR_OFF_LOWER, 16'h00C4);
    cyc(20'h00006, 1'b0, 2'h1);
    chk(sel, 20'hF7FE);
    chk(20'(n), 20'h1);
    wr(csr_pkg::CSR_OFF_PERIPH, 16'h0404);
    cyc(20'h04180, 1'b0, 2'h0);
    chk(sel, 20'hF773);
    wr(csr_pkg::CSR_OFF_COPROC, 16'hF801);
    rd(csr_pkg::CSR_OFF_COPROC, 16'h0000);
    enh = 1'b1;
    cyc(20'h00100, 1'b0, 2'h2);
    chk(sel, 20'hF7F2);
    cyc(20'hFFFF0, 1'b1, 2'h0);
    chk(sel, 20'hF7F3);
    wr(csr_pkg::CSR_OFF_COPROC, 16'hF801);
    rd(csr_pkg::CSR_OFF_COPROC, 16'hF801);
    cyc(20'h0F800, 1'b1, 2'h0);
    chk(sel, 20'h77F3);
    chk(20'({cpr, cpe}), 20'h3);
    wr(csr_pkg::CSR_OFF_MIDBAS, 16'h4000);
    wr(csr_pkg::CSR_OFF_MIDCTL, 16'h0004);
    cyc(20'h41000, 1'b0, 2'h1);
    chk(sel, 20'hB7F3);
    chk(20'(n), 20'h1);
    cyc(20'h0FF00, 1'b0, 2'h0);
    chk(sel, 20'hFFF3);
    cyc(20'h0FF00, 1'b0, 2'h2);
    chk(sel, 20'hF7F3);
    $display("test lower, peripheral and modes done");
    stop_test();
  end

  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule

// file: csr_pin_sync.sv
// Three-stage synchroniser for an input pin, change taken on agreement
`timescale 1ns/1ps
module csr_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       level_reg;
  logic       level_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin_in};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
    if (srst) begin
      stage_next = {3{RST_VAL}};
      level_next = RST_VAL;
    end
  end

  always_ff @(posedge clk) begin
    stage_reg <= stage_next;
    level_reg <= level_next;
  end

  assign level_out = level_reg;
endmodule

// file: csr_pkg.sv
// Constants shared by the chip-select and ready generator
package csr_pkg;
  // ---------------------------------------------------------------
  // Control block offsets (byte offsets inside the 256-byte block)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CSR_OFF_UPPER  = 8'hA0;
  localparam logic [7:0]  CSR_OFF_LOWER  = 8'hA2;
  localparam logic [7:0]  CSR_OFF_PERIPH = 8'hA4;
  localparam logic [7:0]  CSR_OFF_MIDBAS = 8'hA6;
  localparam logic [7:0]  CSR_OFF_MIDCTL = 8'hA8;
  localparam logic [7:0]  CSR_OFF_COPROC = 8'hAA;
  localparam logic [7:0]  CSR_OFF_RELOC  = 8'hFE;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CSR_UPPER_RST  = 16'hFFFB;
  localparam logic [15:0] CSR_RELOC_RST  = 16'h20FF;
  localparam logic [15:0] CSR_ZERO16     = 16'h0000;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSR_RDY_IGN_BIT  = 2;
  localparam int CSR_ADDR_LSB     = 6;
  localparam int CSR_MID_BASE_LSB = 9;
  localparam int CSR_MID_SIZE_LSB = 8;
  localparam int CSR_PER_IO_BIT   = 5;
  localparam int CSR_RELOC_IO_BIT = 12;
  localparam int CSR_MID_BLK_SH   = 13;
  localparam int CSR_PER_BLK_SH   = 7;
  localparam logic [2:0]  CSR_PER_LAST = 3'h7;
  localparam int CSR_NUM_PER      = 7;
  localparam int CSR_NUM_MID      = 4;
  localparam int CSR_SYNC_STAGES  = 3;
  // Bus cycle originator
  typedef enum logic [1:0] {
    CSR_SRC_CPU     = 2'b00,
    CSR_SRC_DMA     = 2'b01,
    CSR_SRC_REFRESH = 2'b10
  } csr_src_type;
  // Ready generator states
  typedef enum logic [1:0] {
    CSR_WS_IDLE = 2'b00,
    CSR_WS_WAIT = 2'b01,
    CSR_WS_DONE = 2'b10
  } csr_ws_type;
endpackage

// file: csr_wait_gen.sv
// Wait-state counter and ready combiner for one bus cycle
`timescale 1ns/1ps
module csr_wait_gen (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cyc_start,
  input  wire logic       cyc_active,
  input  wire logic       hit,
  input  wire logic [1:0] wait_count,
  input  wire logic       ignore_ext,
  input  wire logic       ext_ready,
  output logic            ready_out
);
  csr_pkg::csr_ws_type state_reg;
  csr_pkg::csr_ws_type state_next;
  logic [1:0]          cnt_reg;
  logic [1:0]          cnt_next;
  logic                ign_reg;
  logic                ign_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ign_next   = ign_reg;
    case (state_reg)
      csr_pkg::CSR_WS_IDLE: begin
        if (cyc_start && hit) begin
          cnt_next   = wait_count;
          ign_next   = ignore_ext;
          state_next = (wait_count == 2'h0) ? csr_pkg::CSR_WS_DONE
                                            : csr_pkg::CSR_WS_WAIT;
        end
      end
      csr_pkg::CSR_WS_WAIT: begin
        cnt_next = cnt_reg - 2'h1;
        if (cnt_reg == 2'h1) begin
          state_next = csr_pkg::CSR_WS_DONE;
        end
      end
      csr_pkg::CSR_WS_DONE: begin
        state_next = csr_pkg::CSR_WS_DONE;
      end
      default: begin
        state_next = csr_pkg::CSR_WS_IDLE;
      end
    endcase
    if (!cyc_active || srst) begin
      state_next = csr_pkg::CSR_WS_IDLE;
      cnt_next   = 2'h0;
      ign_next   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
    cnt_reg   <= cnt_next;
    ign_reg   <= ign_next;
  end

  // Programmed waits elapsed, then external ready if it is factored in
  assign ready_out = (state_reg == csr_pkg::CSR_WS_DONE) &&
                     (ign_reg || ext_ready);
endmodule
